// *** design/am_soft_mute_and_seek_floor.sv ***
// AM soft-mute attenuation ramp, its property registers and the seek lower band limit
//
// Function
// - The ramp rate code is scaled by 4.35 dB/s to give the attack and decay rate.
// - The ramp rate property is 16 bits wide, usable 1 to 255, resetting to 0x0040.
// - Attenuation target is the lesser of slope times SNR shortfall and the ceiling.
// - The slope is a 4-bit dB-per-dB field, range 1 to 5, resetting to 2.
// - The attenuation ceiling is a 6-bit whole-dB field, 0 to 63, resetting to 16 dB.
// - A ceiling of zero disables soft mute whatever the SNR.
// - Soft mute engages when SNR is below the engage threshold and the ceiling and slope are non-zero.
// - The engage threshold is a 6-bit field in 1 dB steps, resetting to 10 dB.
// - The seek lower bound is a 16-bit kHz value, valid 149 to 23000, resetting to 520.
// - Below the lower bound a seek halts or wraps as its start command chose.
// - After each property access clear-to-send is raised once the next command may come.
`timescale 1ns/1ps
module am_soft_mute_and_seek_floor
	import am_soft_mute_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic powered_up_i,
	input wire logic prop_wr_i,
	input wire logic prop_rd_i,
	input wire logic [15:0] prop_addr_i,
	input wire logic [15:0] prop_wdata_i,
	input wire logic [6:0] snr_db_i,
	input wire logic seek_start_command_i,
	input wire logic seek_wrap_i,
	input wire logic seek_stop_i,
	input wire logic cand_valid_i,
	input wire logic [15:0] cand_freq_khz_i,
	output logic cts_o,
	output logic [15:0] prop_rdata_o,
	output logic [`DB_W-1:0] attenuation_db_o,
	output logic mute_active_o,
	output logic seek_halt_o,
	output logic seek_wrap_o
);
	mute_state_s st;
	mute_state_s next_st;
	logic access;
	logic tick_hit;
	logic below;
	logic [9:0] shortfall_att;
	logic [`DB_W-1:0] tgt_db;
	logic [`ATT_W-1:0] tgt_fine;
	logic [`STEP_W-1:0] step;
	logic [`STEP_W-1:0] gap;

	// Target attenuation from SNR shortfall, clipped by the ceiling
	always_comb begin
		below = ({1'b0, st.engage_snr_threshold} > snr_db_i);
		shortfall_att = 10'(st.attenuation_slope) *
			10'(7'(st.engage_snr_threshold) - snr_db_i);
		if (st.max_attenuation_db == '0 || !below) begin
			tgt_db = '0;
		end else if (shortfall_att > 10'(st.max_attenuation_db)) begin
			tgt_db = st.max_attenuation_db;
		end else begin
			tgt_db = shortfall_att[`DB_W-1:0];
		end
		tgt_fine = {tgt_db, `FRAC_W'h0};
		step = `STEP_W'(st.ramp_rate_code) * `STEP_W'(`STEP_PER_CODE);
		gap = (st.att > tgt_fine) ? `STEP_W'(st.att - tgt_fine) : `STEP_W'(tgt_fine - st.att);
		tick_hit = (st.tick == `TICK_W'(TICK_CYCLES - 1));
		access = powered_up_i && (prop_wr_i || prop_rd_i);
		// Next state: property access, ramp and seek floor
		next_st = st;
		next_st.cts = 1'b1;
		next_st.halt = 1'b0;
		next_st.wrap = 1'b0;
		// Property writes and reads, one busy cycle each
		if (access) begin
			next_st.cts = 1'b0;
			next_st.rdata = 16'h0;
			if (prop_wr_i) begin
				unique case (prop_addr_i)
					`PROP_RAMP_RATE: next_st.ramp_rate_code = prop_wdata_i;
					`PROP_ATTEN_SLOPE: next_st.attenuation_slope = prop_wdata_i[`SLOPE_W-1:0];
					`PROP_ATTEN_CEILING: next_st.max_attenuation_db = prop_wdata_i[`DB_W-1:0];
					`PROP_ENGAGE_THRESHOLD: next_st.engage_snr_threshold = prop_wdata_i[`DB_W-1:0];
					`PROP_SEEK_LOWER_LIMIT: next_st.seek_lower_bound_khz = prop_wdata_i;
					default: ;
				endcase
			end else begin
				unique case (prop_addr_i)
					`PROP_RAMP_RATE: next_st.rdata = st.ramp_rate_code;
					`PROP_ATTEN_SLOPE: next_st.rdata = 16'(st.attenuation_slope);
					`PROP_ATTEN_CEILING: next_st.rdata = 16'(st.max_attenuation_db);
					`PROP_ENGAGE_THRESHOLD: next_st.rdata = 16'(st.engage_snr_threshold);
					`PROP_SEEK_LOWER_LIMIT: next_st.rdata = st.seek_lower_bound_khz;
					default: ;
				endcase
			end
		end
		// Ramp tick and limited step toward target
		next_st.tick = tick_hit ? '0 : st.tick + `TICK_W'(1);
		if (tick_hit) begin
			if (st.att < tgt_fine) begin
				next_st.att = (gap > step) ? st.att + `ATT_W'(step) : tgt_fine;
			end else if (st.att > tgt_fine) begin
				next_st.att = (gap > step) ? st.att - `ATT_W'(step) : tgt_fine;
			end
		end
		next_st.mute_active = (next_st.att != '0);
		// Seek floor: halt or wrap when a candidate falls below the bound
		if (seek_start_command_i) begin
			next_st.seeking = 1'b1;
			next_st.seek_wrap = seek_wrap_i;
		end else if (st.seeking && seek_stop_i) begin
			next_st.seeking = 1'b0;
		end else if (st.seeking && cand_valid_i && cand_freq_khz_i < st.seek_lower_bound_khz) begin
			if (st.seek_wrap) begin
				next_st.wrap = 1'b1;
			end else begin
				next_st.halt = 1'b1;
				next_st.seeking = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.ramp_rate_code <= `RST_RAMP_RATE;
			st.attenuation_slope <= `RST_ATTEN_SLOPE;
			st.max_attenuation_db <= `RST_ATTEN_CEILING;
			st.engage_snr_threshold <= `RST_ENGAGE_THRESHOLD;
			st.seek_lower_bound_khz <= `RST_SEEK_LOWER_LIMIT;
			st.cts <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign cts_o = st.cts;
	assign prop_rdata_o = st.rdata;
	assign attenuation_db_o = st.att[`ATT_W-1:`FRAC_W];
	assign mute_active_o = st.mute_active;
	assign seek_halt_o = st.halt;
	assign seek_wrap_o = st.wrap;

	// Checks on the design's own behaviour
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence access_taken_s;
		powered_up_i && (prop_wr_i || prop_rd_i);
	endsequence
	sequence cts_pulse_s;
		!cts_o ##1 cts_o;
	endsequence

	// Property port: clear-to-send, stores and readback
	AST_CTS_AFTER_ACCESS: assert property (access_taken_s ##1 !access |-> cts_pulse_s)
		else $error("cts did not drop and return after access");
	AST_RATE_STORE: assert property (access && prop_wr_i && prop_addr_i == `PROP_RAMP_RATE
		|=> st.ramp_rate_code == $past(prop_wdata_i))
		else $error("ramp rate write lost");
	AST_SLOPE_READ: assert property (access && prop_rd_i && !prop_wr_i
		&& prop_addr_i == `PROP_ATTEN_SLOPE
		|=> prop_rdata_o == 16'($past(st.attenuation_slope)))
		else $error("slope readback wrong");
	AST_LIMIT_READ: assert property (access && prop_rd_i && !prop_wr_i
		&& prop_addr_i == `PROP_SEEK_LOWER_LIMIT
		|=> prop_rdata_o == $past(st.seek_lower_bound_khz))
		else $error("lower limit readback wrong");
	// An access while not powered up leaves clear-to-send high
	AST_UNPOWERED_IGNORED: assert property (!powered_up_i |=> cts_o)
		else $error("access taken while not powered up");

	// Attenuation target against slope, threshold and ceiling
	AST_CEILING_CLIP: assert property (tgt_db <= st.max_attenuation_db)
		else $error("target above ceiling");
	AST_ZERO_DISABLES: assert property (st.max_attenuation_db == '0 [*2]
		|-> tgt_db == '0)
		else $error("mute with zero ceiling");
	AST_ZERO_NO_RISE: assert property (st.max_attenuation_db == '0
		|=> st.att <= $past(st.att))
		else $error("attenuation rose with zero ceiling");
	AST_ENGAGE: assert property (st.max_attenuation_db != '0
		&& st.attenuation_slope != '0 && 7'(st.engage_snr_threshold) > snr_db_i
		|-> tgt_db != '0)
		else $error("soft mute not engaged below threshold");

	// Ramp moves only on ticks, by one rate step or onto the target
	AST_RAMP_STEP: assert property (tick_hit && st.att < tgt_fine && gap > step
		|=> st.att == $past(st.att) + `ATT_W'($past(step)))
		else $error("ramp step wrong");
	AST_RAMP_DOWN: assert property (tick_hit && st.att > tgt_fine && gap > step
		|=> st.att == $past(st.att) - `ATT_W'($past(step)))
		else $error("ramp down step wrong");
	AST_RAMP_LAND: assert property (tick_hit && gap <= step
		|=> st.att == $past(tgt_fine))
		else $error("ramp did not land on target");
	AST_RAMP_HOLD: assert property (!tick_hit |=> st.att == $past(st.att))
		else $error("attenuation moved off tick");

	// Seek floor pulses: halt ends the seek, wrap keeps it going
	AST_SEEK_HALT: assert property (st.seeking && !st.seek_wrap && cand_valid_i
		&& cand_freq_khz_i < st.seek_lower_bound_khz && !seek_start_command_i && !seek_stop_i
		|=> seek_halt_o && !st.seeking ##1 !seek_halt_o)
		else $error("seek did not halt at lower bound");
	AST_SEEK_WRAP: assert property (st.seeking && st.seek_wrap && cand_valid_i
		&& cand_freq_khz_i < st.seek_lower_bound_khz && !seek_start_command_i && !seek_stop_i
		|=> seek_wrap_o && st.seeking)
		else $error("seek did not wrap at lower bound");
	AST_SEEK_QUIET: assert property (!st.seeking |=> !seek_halt_o && !seek_wrap_o)
		else $error("seek pulse while idle");

	// First cycle out of reset shows idle outputs and every property default
	AST_RESET_STATE: assert property ($rose(rst_n_i) |-> cts_o && !mute_active_o
		&& attenuation_db_o == '0 && st.ramp_rate_code == `RST_RAMP_RATE
		&& st.attenuation_slope == `RST_ATTEN_SLOPE
		&& st.max_attenuation_db == `RST_ATTEN_CEILING
		&& st.engage_snr_threshold == `RST_ENGAGE_THRESHOLD
		&& st.seek_lower_bound_khz == `RST_SEEK_LOWER_LIMIT)
		else $error("state after reset wrong");
endmodule

// *** design/am_soft_mute_defines.svh ***
// Register offsets, reset values, field widths and timing for the AM soft-mute stage
`ifndef AM_SOFT_MUTE_DEFINES_SVH
`define AM_SOFT_MUTE_DEFINES_SVH
`define PROP_RAMP_RATE 16'h3300
`define PROP_ATTEN_SLOPE 16'h3301
`define PROP_ATTEN_CEILING 16'h3302
`define PROP_ENGAGE_THRESHOLD 16'h3303
`define PROP_SEEK_LOWER_LIMIT 16'h3400
`define RST_RAMP_RATE 16'h0040
`define RST_ATTEN_SLOPE 4'h2
`define RST_ATTEN_CEILING 6'h10
`define RST_ENGAGE_THRESHOLD 6'h0a
`define RST_SEEK_LOWER_LIMIT 16'h0208
`define SLOPE_W 4
`define DB_W 6
`define FRAC_W 16
`define ATT_W 22
`define STEP_W 25
`define TICK_W 17
// Ramp rate unit in centi-dB per second per code, tick period and clock rate
`define RATE_CENTI_DBPS 435
`define TICK_US 1000
`define CLK_MHZ 100
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
// Fine attenuation step per rate code per tick, in 1/65536 dB
`define STEP_PER_CODE ((`RATE_CENTI_DBPS * 65536) / (100 * 1000000 / `TICK_US))
`endif

// *** design/am_soft_mute_pkg.sv ***
// Types for the AM soft-mute and seek-floor block
`include "am_soft_mute_defines.svh"
package am_soft_mute_pkg;
	typedef struct packed {
		logic [15:0] ramp_rate_code;
		logic [`SLOPE_W-1:0] attenuation_slope;
		logic [`DB_W-1:0] max_attenuation_db;
		logic [`DB_W-1:0] engage_snr_threshold;
		logic [15:0] seek_lower_bound_khz;
		logic [`ATT_W-1:0] att;
		logic [`TICK_W-1:0] tick;
		logic cts;
		logic [15:0] rdata;
		logic seeking;
		logic seek_wrap;
		logic halt;
		logic wrap;
		logic mute_active;
	} mute_state_s;
endpackage

// *** tb/sys_ctrl_model.sv ***
// System controller model that issues property accesses
`timescale 1ns/1ps
module sys_ctrl_model (
	input wire logic clk_sys_i,
	input wire logic cts_i,
	input wire logic [15:0] rdata_i,
	output logic powered_up_o,
	output logic prop_wr_o,
	output logic prop_rd_o,
	output logic [15:0] prop_addr_o,
	output logic [15:0] prop_wdata_o
);
	// Idle bus, device powered up
	initial begin
		powered_up_o = 1'b1;
		prop_wr_o = 1'b0;
		prop_rd_o = 1'b0;
		prop_addr_o = 16'h0000;
		prop_wdata_o = 16'h0000;
	end
	// Power mode switch, commanded by the bench
	task automatic set_power(input logic on);
		@(posedge clk_sys_i);
		powered_up_o <= on;
	endtask
	// One access; reports clear-to-send and read data of the answer cycle
	task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
			output logic [15:0] rdata, output logic cts_low);
		@(posedge clk_sys_i);
		prop_wr_o <= wr;
		prop_rd_o <= !wr;
		prop_addr_o <= addr;
		prop_wdata_o <= wdata;
		@(posedge clk_sys_i);
		prop_wr_o <= 1'b0;
		prop_rd_o <= 1'b0;
		prop_addr_o <= ~addr; // Released bus no longer shows the last value
		prop_wdata_o <= ~wdata;
		#1;
		cts_low = !cts_i;
		rdata = rdata_i;
	endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the AM soft-mute and seek-floor block
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, seek_start_command_i = 1'b0, seek_wrap_i = 1'b0;
	logic seek_stop_i = 1'b0, cand_valid_i = 1'b0, pwr, wr, rd, cts, mute, halt, wrap;
	logic [6:0] snr_db_i = 7'h3f;
	logic [15:0] cand_freq_khz_i = 16'h0000, addr, wdata, rdata;
	logic [5:0] att;
	logic [15:0] adr [5] = '{16'h3300, 16'h3301, 16'h3302, 16'h3303, 16'h3400};
	logic [15:0] rst [5] = '{16'h0040, 16'h0002, 16'h0010, 16'h000a, 16'h0208};
	logic [15:0] msk [5] = '{16'hffff, 16'h000f, 16'h003f, 16'h003f, 16'hffff};
	logic [15:0] d;
	logic c;
	int fail_count = 0, compares = 0, cycles = 0;
	am_soft_mute_and_seek_floor #(.TICK_CYCLES(10)) i_dut (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .powered_up_i(pwr), .prop_wr_i(wr), .prop_rd_i(rd),
		.prop_addr_i(addr), .prop_wdata_i(wdata), .snr_db_i(snr_db_i),
		.seek_start_command_i(seek_start_command_i), .seek_wrap_i(seek_wrap_i),
		.seek_stop_i(seek_stop_i), .cand_valid_i(cand_valid_i),
		.cand_freq_khz_i(cand_freq_khz_i), .cts_o(cts), .prop_rdata_o(rdata),
		.attenuation_db_o(att), .mute_active_o(mute), .seek_halt_o(halt), .seek_wrap_o(wrap));
	sys_ctrl_model i_ctrl (.clk_sys_i(clk_sys_i), .cts_i(cts), .rdata_i(rdata),
		.powered_up_o(pwr), .prop_wr_o(wr), .prop_rd_o(rd), .prop_addr_o(addr),
		.prop_wdata_o(wdata));
	// Clock and hang guard
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wt(input int n, input logic [5:0] ea, input logic em);
		repeat (n) @(posedge clk_sys_i);
		#1 chk("attenuation", {10'h000, att}, {10'h000, ea});
		chk("mute", mute, em);
	endtask
	// Reset values, field widths, unmapped place and power gating
	task automatic test_regs();
		for (int i = 0; i < 5; i++) begin
			i_ctrl.access(1'b0, adr[i], 16'h0000, d, c);
			chk("cts", c, 1'b1);
			chk("reset", d, rst[i]);
			i_ctrl.access(1'b1, adr[i], 16'hffff, d, c);
			i_ctrl.access(1'b0, adr[i], 16'h0000, d, c);
			chk("width", d, msk[i]);
			i_ctrl.access(1'b1, adr[i], rst[i], d, c);
		end
		i_ctrl.access(1'b0, 16'h3304, 16'h0000, d, c);
		chk("unmapped", d, 16'h0000);
		i_ctrl.set_power(1'b0);
		i_ctrl.access(1'b1, 16'h3302, 16'h0001, d, c);
		chk("unpowered cts", c, 1'b0);
		i_ctrl.set_power(1'b1);
		i_ctrl.access(1'b0, 16'h3302, 16'h0000, d, c);
		chk("kept", d, 16'h0010);
	endtask
	// Ramp up, ceiling, disable, threshold edge and faster rate; slope 2 = ceil(16/10)
	task automatic test_mute();
		@(posedge clk_sys_i) snr_db_i <= 7'd5;
		wt(200, 6'd5, 1'b1);
		wt(200, 6'd10, 1'b1);
		@(posedge clk_sys_i) snr_db_i <= 7'd0;
		wt(300, 6'd16, 1'b1);
		i_ctrl.access(1'b1, 16'h3302, 16'h0000, d, c);
		wt(700, 6'd0, 1'b0);
		i_ctrl.access(1'b1, 16'h3302, 16'h0010, d, c);
		@(posedge clk_sys_i) snr_db_i <= 7'd10;
		wt(100, 6'd0, 1'b0);
		i_ctrl.access(1'b1, 16'h3300, 16'h00ff, d, c);
		@(posedge clk_sys_i) snr_db_i <= 7'd5;
		wt(120, 6'd10, 1'b1);
		@(posedge clk_sys_i) snr_db_i <= 7'h3f;
		wt(120, 6'd0, 1'b0);
		i_ctrl.access(1'b1, 16'h3300, 16'h0040, d, c);
	endtask
	task automatic start(input logic w, input logic s);
		@(posedge clk_sys_i);
		seek_start_command_i <= !s;
		seek_stop_i <= s;
		seek_wrap_i <= w;
		@(posedge clk_sys_i);
		seek_start_command_i <= 1'b0;
		seek_stop_i <= 1'b0;
	endtask
	task automatic cand(input logic [15:0] f, input logic eh, input logic ew);
		cand_freq_khz_i <= f;
		cand_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		cand_valid_i <= 1'b0;
		#1 chk("halt", halt, eh);
		chk("wrap", wrap, ew);
		@(posedge clk_sys_i);
	endtask
	// Halt and wrap at the lower band limit, then a moved limit
	task automatic test_seek();
		start(1'b0, 1'b0);
		cand(16'd520, 1'b0, 1'b0);
		cand(16'd519, 1'b1, 1'b0);
		cand(16'd500, 1'b0, 1'b0);
		start(1'b1, 1'b0);
		cand(16'd519, 1'b0, 1'b1);
		cand(16'd400, 1'b0, 1'b1);
		start(1'b0, 1'b1);
		cand(16'd400, 1'b0, 1'b0);
		i_ctrl.access(1'b1, 16'h3400, 16'd153, d, c);
		start(1'b0, 1'b0);
		cand(16'd154, 1'b0, 1'b0);
		cand(16'd152, 1'b1, 1'b0);
	endtask
	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		test_regs();
		test_mute();
		test_seek();
		finish_test();
	end
endmodule
